// ==== design/gdram_consts.svh ====
// timing and field constants for the graphics DRAM command controller
// Function
// - write latency is programmable from 1 to 7 clocks; program only legal values
// - latency 4 to 7 opens buffers at write; latency must exceed 7 ns
// - no rising strobe edge in the half clock before the write preamble
// - after the postamble the last strobe rise is actively driven high
// - first latching strobe edge lands at write latency after the write command
// - after auto refresh wait the refresh row cycle before any command
// - wait the row-to-read delay between activation and read
// - wait the row-to-write delay between activation and write
// - space activations by at least the activate-to-activate delay
// - wait write recovery after last write beat before precharging the bank
// - wait the write-to-read turnaround after last write beat before a read
// - wait the mode set cycle after a mode register set
// - after write with autoprecharge wait recovery plus precharge before activation
// - after self refresh exit wait 20000 clocks before any read
// - after self refresh exit wait 100 clocks before any other command
// - every row is refreshed within a 32 ms refresh period
`ifndef GDRAM_CONSTS_SVH
`define GDRAM_CONSTS_SVH
`define TCK_NS 4
`define WL_MIN_NS 7
`define REFI_NS 7800
`define REFI_CK (`REFI_NS / `TCK_NS)
`define REF_ROW_CK 52
`define ROW_RD_CK 14
`define ROW_WR_CK 10
`define ACT_ACT_CK 10
`define WR_RECOV_CK 13
`define WR_RD_CK 7
`define MODE_SET_CK 9
`define AP_WR_CK 25
`define SR_EXIT_RD_CK 20000
`define SR_EXIT_OTHER_CK 100
`define ROW_ACT_MIN_CK 29
`define ROW_ACT_MAX_CK 100000
`define ROW_CYCLE_CK 41
`define ROW_PRE_CK 12
`define PD_EXIT_CK 9
`define BURST_LEN 4
`define AP_BIT 8
`define MRS_WL_LSB 9
`define WL_RST 3'h4
`endif

// ==== design/gdram_pkg.sv ====
// types shared by the graphics DRAM command controller
`default_nettype none
package gdram_pkg;
	typedef enum logic [3:0] {C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_REF, C_MRS, C_SRE, C_SRX, C_PDE, C_PDX} cmd_t;
	typedef enum logic [1:0] {ST_RUN = 2'h0, ST_SELFREF = 2'h1, ST_PWRDN = 2'h3} pwr_t;
	typedef struct packed {
		logic valid;
		cmd_t cmd;
		logic [1:0] bank;
		logic [11:0] addr;
		logic autopre;
		logic [2:0] wl;
	} req_t;
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] ba;
		logic [11:0] a;
	} pins_t;
	typedef struct packed {
		logic open;
		logic ap_wr;
		logic [16:0] since_act;
		logic [7:0] since_pre;
		logic [7:0] since_wr;
	} bank_t;
	typedef struct packed {
		pins_t pins;
		logic [1:0] strobe;
		logic strobe_oe;
		logic ready;
		logic err;
		logic ref_due;
		logic overdue;
		req_t hold;
		pwr_t pwr;
		logic [2:0] wl;
		bank_t [3:0] bk;
		logic [7:0] since_act;
		logic [7:0] since_ref;
		logic [7:0] since_mrs;
		logic [7:0] since_wr;
		logic [14:0] since_exit;
		logic exit_sr;
		logic [15:0] refi;
		logic ws_on;
		logic [3:0] ws_ph;
	} state_t;
endpackage
`default_nettype wire

// ==== design/graphics_dram_cmd_timing.sv ====
// command scheduler that drives a four-bank graphics DRAM within its timing limits
`timescale 1ns/10ps
`default_nettype none
`include "gdram_consts.svh"
module graphics_dram_cmd_timing #(
	parameter int REF_CYC = `REF_ROW_CK,
	parameter int ROW_RD = `ROW_RD_CK,
	parameter int ROW_WR = `ROW_WR_CK,
	parameter int ACT_ACT = `ACT_ACT_CK,
	parameter int WR_RECOV = `WR_RECOV_CK,
	parameter int WR_RD = `WR_RD_CK,
	parameter int MODE_SET = `MODE_SET_CK,
	parameter int AP_WR = `AP_WR_CK,
	parameter int SR_EXIT_RD = `SR_EXIT_RD_CK,
	parameter int SR_EXIT_OTHER = `SR_EXIT_OTHER_CK,
	parameter int ROW_ACT_MIN = `ROW_ACT_MIN_CK,
	parameter int ROW_ACT_MAX = `ROW_ACT_MAX_CK,
	parameter int ROW_CYCLE = `ROW_CYCLE_CK,
	parameter int ROW_PRE = `ROW_PRE_CK,
	parameter int PD_EXIT = `PD_EXIT_CK,
	parameter int REFI_CYC = `REFI_CK
)(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CE,
	input wire gdram_pkg::req_t REQ,
	output var gdram_pkg::pins_t MEM,
	output var logic [1:0] STROBE,
	output var logic STROBE_OE,
	output var logic REQ_READY,
	output var logic REQ_ERR,
	output var logic REFRESH_DUE,
	output var logic ROW_OVERDUE
);
	import gdram_pkg::*;

	localparam int HALF_BL = `BURST_LEN / 2;

	// enough cycles have passed once the command after this cycle is placed
	function automatic logic met(input int cnt, input int t);
		return cnt + 1 >= t;
	endfunction

	// pin encoding of a command
	function automatic pins_t enc(input cmd_t c, input logic cke, input logic [1:0] ba, input logic [11:0] a);
		pins_t p;
		p = '{cke: cke, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: ba, a: a};
		case (c)
			C_ACT: p.ras_n = 1'b0;
			C_RD: p.cas_n = 1'b0;
			C_WR: begin
				p.cas_n = 1'b0;
				p.we_n = 1'b0;
			end
			C_PRE: begin
				p.ras_n = 1'b0;
				p.we_n = 1'b0;
			end
			C_REF, C_SRE: begin
				p.ras_n = 1'b0;
				p.cas_n = 1'b0;
			end
			C_MRS: begin
				p.ras_n = 1'b0;
				p.cas_n = 1'b0;
				p.we_n = 1'b0;
			end
			default: p.cs_n = 1'b0;
		endcase
		return p;
	endfunction

	// command seen on the pins, for checking
	function automatic cmd_t dec(input pins_t p);
		case ({p.cs_n, p.ras_n, p.cas_n, p.we_n})
			4'h3: return C_ACT;
			4'h5: return C_RD;
			4'h4: return C_WR;
			4'h2: return C_PRE;
			4'h1: return C_REF;
			4'h0: return C_MRS;
			default: return C_NOP;
		endcase
	endfunction

	// reset image of the whole state
	function automatic state_t init_state();
		state_t t;
		t = '0;
		t.pins = enc(C_NOP, 1'b1, 2'h0, 12'h000);
		t.ready = 1'b1;
		t.pwr = ST_RUN;
		t.wl = `WL_RST;
		t.since_act = '1;
		t.since_ref = '1;
		t.since_mrs = '1;
		t.since_wr = '1;
		t.since_exit = '1;
		t.refi = '0;
		for (int i = 0; i < 4; i++) begin
			t.bk[i].since_act = '1;
			t.bk[i].since_pre = '1;
			t.bk[i].since_wr = '1;
		end
		return t;
	endfunction

	localparam state_t ST_INIT = init_state();

	state_t st_r;
	state_t st_nxt;

	// next state: ageing, legality and timing checks, issue, strobe sequence
	always_comb begin
		int wlast;
		int k;
		logic legal;
		logic ok;
		logic idle;
		logic exit_ok;
		cmd_t c;
		logic [1:0] b;
		bank_t bk;
		wlast = 0;
		k = 0;
		legal = 1'b0;
		ok = 1'b0;
		idle = 1'b1;
		exit_ok = 1'b1;
		c = st_r.hold.cmd;
		b = st_r.hold.bank;
		bk = st_r.bk[b];
		st_nxt = st_r;
		st_nxt.err = 1'b0;
		st_nxt.pins = enc(C_NOP, st_r.pins.cke, st_r.pins.ba, st_r.pins.a);
		wlast = int'(st_r.wl) + HALF_BL;
		// saturating age counters
		if (~&st_nxt.since_act) st_nxt.since_act = st_nxt.since_act + 8'h01;
		if (~&st_nxt.since_ref) st_nxt.since_ref = st_nxt.since_ref + 8'h01;
		if (~&st_nxt.since_mrs) st_nxt.since_mrs = st_nxt.since_mrs + 8'h01;
		if (~&st_nxt.since_wr) st_nxt.since_wr = st_nxt.since_wr + 8'h01;
		if (~&st_nxt.since_exit) st_nxt.since_exit = st_nxt.since_exit + 15'h0001;
		st_nxt.overdue = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (~&st_nxt.bk[i].since_act) st_nxt.bk[i].since_act = st_nxt.bk[i].since_act + 17'h00001;
			if (~&st_nxt.bk[i].since_pre) st_nxt.bk[i].since_pre = st_nxt.bk[i].since_pre + 8'h01;
			if (~&st_nxt.bk[i].since_wr) st_nxt.bk[i].since_wr = st_nxt.bk[i].since_wr + 8'h01;
			// banks idle only after precharge and recovery
			if (st_r.bk[i].open || !met(int'(st_r.bk[i].since_pre), ROW_PRE)) idle = 1'b0;
			if (st_r.bk[i].ap_wr && !met(int'(st_r.bk[i].since_wr), wlast + AP_WR)) idle = 1'b0;
			if (st_r.bk[i].open && int'(st_r.bk[i].since_act) >= ROW_ACT_MAX) st_nxt.overdue = 1'b1;
		end
		ok = met(int'(st_r.since_ref), REF_CYC);
		ok = ok && met(int'(st_r.since_mrs), MODE_SET);
		if (c == C_RD) exit_ok = met(int'(st_r.since_exit), st_r.exit_sr ? SR_EXIT_RD : PD_EXIT);
		else exit_ok = met(int'(st_r.since_exit), st_r.exit_sr ? SR_EXIT_OTHER : PD_EXIT);
		ok = ok && exit_ok;
		legal = (st_r.pwr == ST_RUN);
		case (c)
			C_ACT: begin
				legal = legal && !bk.open;
				ok = ok && met(int'(st_r.since_act), ACT_ACT);
				ok = ok && met(int'(bk.since_act), ROW_CYCLE) && met(int'(bk.since_pre), ROW_PRE);
				ok = ok && (!bk.ap_wr || met(int'(bk.since_wr), wlast + AP_WR));
			end
			C_RD: begin
				legal = legal && bk.open;
				ok = ok && met(int'(bk.since_act), ROW_RD);
				ok = ok && met(int'(st_r.since_wr), wlast + WR_RD);
			end
			C_WR: begin
				legal = legal && bk.open;
				ok = ok && met(int'(bk.since_act), ROW_WR) && !st_r.ws_on;
			end
			C_PRE: begin
				ok = ok && (!bk.open || met(int'(bk.since_act), ROW_ACT_MIN));
				ok = ok && met(int'(bk.since_wr), wlast + WR_RECOV);
			end
			C_REF, C_SRE: ok = ok && idle;
			C_MRS: begin
				legal = legal && (st_r.hold.wl != 3'h0);
				// long latencies must span more than the minimum time
				legal = legal && (st_r.hold.wl < 3'h4 || int'(st_r.hold.wl) * `TCK_NS > `WL_MIN_NS);
				ok = ok && idle;
			end
			C_SRX: begin
				legal = (st_r.pwr == ST_SELFREF);
				ok = 1'b1;
			end
			C_PDX: begin
				legal = (st_r.pwr == ST_PWRDN);
				ok = 1'b1;
			end
			default: ;
		endcase
		// issue or refuse the held request
		if (st_r.hold.valid) begin
			if (!legal) begin
				st_nxt.err = 1'b1;
				st_nxt.hold.valid = 1'b0;
			end else if (ok) begin
				st_nxt.hold.valid = 1'b0;
				st_nxt.pins = enc(c, st_r.pins.cke, b, st_r.hold.addr);
				case (c)
					C_ACT: begin
						st_nxt.since_act = 8'h00;
						st_nxt.bk[b].open = 1'b1;
						st_nxt.bk[b].ap_wr = 1'b0;
						st_nxt.bk[b].since_act = 17'h00000;
					end
					C_RD, C_WR: begin
						st_nxt.pins.a[`AP_BIT] = st_r.hold.autopre;
						if (c == C_WR) begin
							st_nxt.since_wr = 8'h00;
							st_nxt.bk[b].since_wr = 8'h00;
							st_nxt.ws_on = 1'b1;
							st_nxt.ws_ph = 4'h0;
						end
						if (st_r.hold.autopre) begin
							st_nxt.bk[b].open = 1'b0;
							st_nxt.bk[b].ap_wr = (c == C_WR);
							st_nxt.bk[b].since_pre = 8'h00;
						end
					end
					C_PRE: begin
						st_nxt.pins.a[`AP_BIT] = 1'b0;
						if (bk.open) st_nxt.bk[b].since_pre = 8'h00;
						st_nxt.bk[b].open = 1'b0;
					end
					C_REF: begin
						st_nxt.since_ref = 8'h00;
						st_nxt.refi = 16'h0000;
					end
					C_MRS: begin
						st_nxt.since_mrs = 8'h00;
						st_nxt.wl = st_r.hold.wl;
						st_nxt.pins.a[`MRS_WL_LSB +: 3] = st_r.hold.wl;
					end
					C_SRE, C_PDE: begin
						st_nxt.pins.cke = 1'b0;
						st_nxt.pwr = (c == C_SRE) ? ST_SELFREF : ST_PWRDN;
					end
					C_SRX, C_PDX: begin
						st_nxt.pins.cke = 1'b1;
						st_nxt.pwr = ST_RUN;
						st_nxt.since_exit = 15'h0000;
						st_nxt.exit_sr = (c == C_SRX);
						if (c == C_SRX) st_nxt.refi = 16'h0000;
					end
					default: ;
				endcase
			end
		end
		// average refresh interval; follows from it
		if (st_nxt.pwr == ST_SELFREF) st_nxt.refi = 16'h0000;
		else if (~&st_nxt.refi && st_nxt.refi == st_r.refi) st_nxt.refi = st_nxt.refi + 16'h0001;
		st_nxt.ref_due = (int'(st_nxt.refi) >= REFI_CYC);
		// accept a new request into the empty holding slot
		if (st_r.ready && REQ.valid) st_nxt.hold = REQ;
		st_nxt.ready = !st_nxt.hold.valid;
		// write strobe phase, k counts cycles after the write command
		if (st_r.ws_on && !(st_r.hold.valid && c == C_WR && legal && ok)) begin
			if (int'(st_r.ws_ph) >= wlast + 1) st_nxt.ws_on = 1'b0;
			else st_nxt.ws_ph = st_r.ws_ph + 4'h1;
		end
		k = int'(st_nxt.ws_ph);
		st_nxt.strobe_oe = st_nxt.ws_on && (k >= int'(st_nxt.wl) - 1);
		st_nxt.strobe = 2'h0;
		if (st_nxt.strobe_oe) begin
			if (k == int'(st_nxt.wl) - 1) st_nxt.strobe = 2'h0;
			// first rise exactly at write latency
			else if (k < int'(st_nxt.wl) + HALF_BL) st_nxt.strobe = 2'h2;
			// postamble then a driven high level
			else if (k == int'(st_nxt.wl) + HALF_BL) st_nxt.strobe = 2'h1;
			else st_nxt.strobe = 2'h3;
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= ST_INIT;
		end else if (CE) begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign MEM = st_r.pins;
	assign STROBE = st_r.strobe;
	assign STROBE_OE = st_r.strobe_oe;
	assign REQ_READY = st_r.ready;
	assign REQ_ERR = st_r.err;
	assign REFRESH_DUE = st_r.ref_due;
	assign ROW_OVERDUE = st_r.overdue;

	// checks on the pins against the programmed limits
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N || !CE);

	cmd_t pc;
	assign pc = st_r.pins.cke ? dec(st_r.pins) : C_NOP;

	sequence s_pre;
		STROBE_OE && STROBE == 2'h0;
	endsequence
	sequence s_beat;
		STROBE_OE && STROBE == 2'h2;
	endsequence

	property p_act_gap;
		pc == C_ACT |-> int'($past(st_r.since_act)) + 1 >= ACT_ACT;
	endproperty
	a_act_gap: assert property (p_act_gap) else $error("activations too close");
	property p_ref_gap;
		pc != C_NOP |-> int'($past(st_r.since_ref)) + 1 >= REF_CYC;
	endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("command inside refresh row cycle");
	property p_mode_gap;
		pc != C_NOP |-> int'($past(st_r.since_mrs)) + 1 >= MODE_SET;
	endproperty
	a_mode_gap: assert property (p_mode_gap) else $error("command inside mode set cycle");
	property p_sr_rd;
		pc == C_RD && st_r.exit_sr |-> int'($past(st_r.since_exit)) + 1 >= SR_EXIT_RD;
	endproperty
	a_sr_rd: assert property (p_sr_rd) else $error("read too soon after self refresh exit");
	property p_sr_other;
		pc != C_NOP && pc != C_RD && st_r.exit_sr |-> int'($past(st_r.since_exit)) + 1 >= SR_EXIT_OTHER;
	endproperty
	a_sr_other: assert property (p_sr_other) else $error("command too soon after self refresh exit");
	property p_row_rd;
		pc == C_RD |-> int'($past(st_r.bk[st_r.hold.bank].since_act)) + 1 >= ROW_RD;
	endproperty
	a_row_rd: assert property (p_row_rd) else $error("read too soon after activation");
	property p_first_edge;
		pc == C_WR && st_r.wl == 3'h4 |-> ##3 s_pre ##1 s_beat;
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("first strobe edge off latency");
	property p_preamble;
		STROBE_OE && STROBE == 2'h2 && !$past(STROBE_OE && STROBE == 2'h2) |-> $past(STROBE_OE) && $past(STROBE) == 2'h0;
	endproperty
	a_preamble: assert property (p_preamble) else $error("strobe rose without low preamble");
	property p_postamble;
		$fell(STROBE_OE) |-> $past(STROBE) == 2'h3;
	endproperty
	a_postamble: assert property (p_postamble) else $error("strobe released without driven high");
	property p_wl_legal;
		pc == C_MRS |-> st_r.wl != 3'h0 && (st_r.wl < 3'h4 || int'(st_r.wl) * `TCK_NS > `WL_MIN_NS);
	endproperty
	a_wl_legal: assert property (p_wl_legal) else $error("illegal write latency programmed");
endmodule
`default_nettype wire

// ==== tb/gdram_device_model.sv ====
// memory device model: decodes commands on the pins and counts spacing breaches
`timescale 1ns/10ps
`default_nettype none
`include "gdram_consts.svh"
module gdram_device_model #(
	parameter int ROW_RD = `ROW_RD_CK,
	parameter int ROW_WR = `ROW_WR_CK,
	parameter int ACT_ACT = `ACT_ACT_CK,
	parameter int REF_CYC = `REF_ROW_CK,
	parameter int MODE_SET = `MODE_SET_CK
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire gdram_pkg::pins_t mem,
	output var gdram_pkg::cmd_t cmd,
	output var logic [7:0] viol,
	output var logic [2:0] wl,
	output var logic buf_on
);
	import gdram_pkg::*;
	logic prev_cke;
	int s_act[4];
	int s_aa;
	int s_ref;
	int s_mrs;
	int bad;
	// decode the pin pattern; cke edges mark self refresh entry and exit
	always_comb begin
		cmd = C_NOP;
		if (!mem.cke) begin
			if (prev_cke && !mem.cs_n && {mem.ras_n, mem.cas_n, mem.we_n} == 3'b001) cmd = C_SRE;
		end else if (!prev_cke) begin
			cmd = C_SRX;
		end else if (!mem.cs_n) begin
			case ({mem.ras_n, mem.cas_n, mem.we_n})
				3'b011: cmd = C_ACT;
				3'b101: cmd = C_RD;
				3'b100: cmd = C_WR;
				3'b010: cmd = C_PRE;
				3'b001: cmd = C_REF;
				3'b000: cmd = C_MRS;
				default: cmd = C_NOP;
			endcase
		end
	end
	// age counters, mode state and breach count
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_cke <= 1'b1;
			viol <= 8'h00;
			wl <= 3'h4;
			buf_on <= 1'b0;
			s_aa <= 999;
			s_ref <= 999;
			s_mrs <= 999;
			s_act <= '{default: 999};
		end else begin
			bad = 0;
			prev_cke <= mem.cke;
			s_aa <= s_aa + 1;
			s_ref <= s_ref + 1;
			s_mrs <= s_mrs + 1;
			foreach (s_act[i]) s_act[i] <= s_act[i] + 1;
			// quiet after refresh or mode set
			if (cmd != C_NOP && (s_ref < REF_CYC || s_mrs < MODE_SET)) bad++;
			case (cmd)
				C_ACT: begin
					if (s_aa < ACT_ACT) bad++;
					s_aa <= 1;
					s_act[mem.ba] <= 1;
					// buffers at activation only for short latency
					buf_on <= (wl <= 3'h3);
				end
				C_RD: if (s_act[mem.ba] < ROW_RD) bad++;
				C_WR: begin
					if (s_act[mem.ba] < ROW_WR) bad++;
					buf_on <= 1'b1;
				end
				C_REF: s_ref <= 1;
				C_MRS: begin
					if (mem.a[11:9] == 3'h0) bad++;
					wl <= mem.a[11:9];
					s_mrs <= 1;
				end
				default: ;
			endcase
			viol <= viol + 8'(bad);
		end
	end
endmodule
`default_nettype wire

// ==== tb/graphics_dram_cmd_timing_tb_top.sv ====
// self-checking bench for the graphics DRAM command controller
`timescale 1ns/10ps
`default_nettype none
`include "gdram_consts.svh"
module graphics_dram_cmd_timing_tb_top;
	import gdram_pkg::*;
	localparam int SR_RD = 50;
	localparam int SR_OT = 20;
	localparam int RMAX = 200;
	localparam int REFI = 100;
	logic CLOCK, RST_N, CE;
	req_t REQ;
	pins_t MEM;
	logic [1:0] STROBE;
	logic STROBE_OE, REQ_READY, REQ_ERR, REFRESH_DUE, ROW_OVERDUE;
	cmd_t dev_cmd;
	logic [7:0] dev_viol;
	logic [2:0] dev_wl;
	logic dev_buf;
	int n_mismatch, cmp_count, cyc, t_open;
	int t_of[16];
	logic [2:0] hist[64];
	logic err_seen, wr_ap;
	graphics_dram_cmd_timing #(.SR_EXIT_RD(SR_RD), .ROW_ACT_MAX(RMAX), .REFI_CYC(REFI), .SR_EXIT_OTHER(SR_OT))
	graphics_dram_cmd_timing_i (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .REQ(REQ), .MEM(MEM), .STROBE(STROBE),
		.STROBE_OE(STROBE_OE), .REQ_READY(REQ_READY), .REQ_ERR(REQ_ERR), .REFRESH_DUE(REFRESH_DUE),
		.ROW_OVERDUE(ROW_OVERDUE));
	gdram_device_model gdram_device_model_i (.clk(CLOCK), .rst_n(RST_N), .mem(MEM), .cmd(dev_cmd),
		.viol(dev_viol), .wl(dev_wl), .buf_on(dev_buf));
	// free-running 4 ns clock
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	// log command times, strobe history and error pulses
	always @(posedge CLOCK) begin
		cyc = cyc + 1;
		hist[cyc % 64] = {STROBE_OE, STROBE};
		if (dev_cmd != C_NOP) t_of[dev_cmd] = cyc;
		if (dev_cmd == C_WR) wr_ap = MEM.a[8];
		if (REQ_ERR === 1'b1) err_seen = 1'b1;
	end
	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		@(posedge CLOCK);
		#1;
	endtask
	// one cycle of a bounded wait; running out ends the run
	task automatic guard(inout int n, input int lim);
		tick();
		n++;
		if (n > lim) begin
			n_mismatch++;
			test_done();
		end
	endtask
	function automatic int gap(cmd_t a, cmd_t b);
		return t_of[a] - t_of[b];
	endfunction
	// present one request, then wait until it is issued or dropped
	task automatic send(cmd_t c, logic [1:0] b, logic ap, logic [2:0] w);
		int n;
		n = 0;
		while (REQ_READY !== 1'b1) guard(n, 30000);
		err_seen = 1'b0;
		REQ = req_t'{valid: 1'b1, cmd: c, bank: b, addr: 12'h000, autopre: ap, wl: w};
		tick();
		REQ.valid = 1'b0;
		n = 0;
		while (REQ_READY !== 1'b1) guard(n, 30000);
		tick();
	endtask
	task automatic t_reset();
		chk(32'(MEM), 32'(pins_t'{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000}));
		chk({STROBE_OE, STROBE, REQ_READY, REQ_ERR, REFRESH_DUE, ROW_OVERDUE}, 7'h08);
	endtask
	task automatic t_refresh();
		int n;
		n = 0;
		while (REFRESH_DUE !== 1'b1) guard(n, 500);
		chk(32'(n >= REFI - 3 && n <= REFI + 3), 1);
		send(C_REF, 2'h0, 1'b0, 3'h0);
		chk(REFRESH_DUE, 0);
		send(C_ACT, 2'h0, 1'b0, 3'h0);
		t_open = t_of[C_ACT];
		chk(32'(gap(C_ACT, C_REF) >= `REF_ROW_CK), 1);
	endtask
	task automatic t_rows();
		int n;
		send(C_ACT, 2'h1, 1'b0, 3'h0);
		chk(32'(t_of[C_ACT] - t_open >= `ACT_ACT_CK), 1);
		send(C_RD, 2'h1, 1'b0, 3'h0);
		chk(32'(gap(C_RD, C_ACT) >= `ROW_RD_CK), 1);
		send(C_ACT, 2'h1, 1'b0, 3'h0);
		chk(err_seen, 1);
		send(C_RD, 2'h2, 1'b0, 3'h0);
		chk(err_seen, 1);
		n = 0;
		while (ROW_OVERDUE !== 1'b1) guard(n, 400);
		chk(32'(cyc - t_open >= RMAX - 2 && cyc - t_open <= RMAX + 2), 1);
		send(C_PRE, 2'h0, 1'b0, 3'h0);
		send(C_PRE, 2'h1, 1'b0, 3'h0);
		tick();
		chk(ROW_OVERDUE, 0);
	endtask
	task automatic t_write(input logic [2:0] w);
		int t;
		logic [1:0] pat;
		send(C_MRS, 2'h0, 1'b0, w);
		chk(dev_wl, w);
		send(C_ACT, 2'h3, 1'b0, 3'h0);
		chk(32'(gap(C_ACT, C_MRS) >= `MODE_SET_CK), 1);
		chk(dev_buf, 32'(w <= 3'h3));
		send(C_WR, 2'h3, 1'b0, 3'h0);
		chk(32'(gap(C_WR, C_ACT) >= `ROW_WR_CK), 1);
		chk(dev_buf, 1);
		t = t_of[C_WR];
		repeat (w + 6) tick();
		for (int k = 0; k <= w + 4; k++) begin
			pat = (k + 1 == w) ? 2'b00 : (k <= w + 1) ? 2'b10 : (k == w + 2) ? 2'b01 : 2'b11;
			if (k + 1 >= w && k <= w + 3) chk(hist[(t + k) % 64], {1'b1, pat});
			else chk(hist[(t + k) % 64][2], 0);
		end
		send(C_RD, 2'h3, 1'b0, 3'h0);
		chk(32'(gap(C_RD, C_WR) >= w + 2 + `WR_RD_CK), 1);
		send(C_PRE, 2'h3, 1'b0, 3'h0);
		chk(32'(gap(C_PRE, C_WR) >= w + 2 + `WR_RECOV_CK), 1);
	endtask
	task automatic t_autopre();
		int ta;
		send(C_ACT, 2'h2, 1'b0, 3'h0);
		send(C_WR, 2'h2, 1'b1, 3'h0);
		chk(wr_ap, 1);
		ta = t_of[C_WR];
		send(C_ACT, 2'h2, 1'b0, 3'h0);
		chk(32'(t_of[C_ACT] - ta >= 7 + 2 + `AP_WR_CK), 1);
		send(C_PRE, 2'h2, 1'b0, 3'h0);
	endtask
	task automatic t_selfref();
		send(C_SRE, 2'h0, 1'b0, 3'h0);
		chk(MEM.cke, 0);
		send(C_ACT, 2'h0, 1'b0, 3'h0);
		chk(err_seen, 1);
		send(C_SRX, 2'h0, 1'b0, 3'h0);
		send(C_ACT, 2'h0, 1'b0, 3'h0);
		chk(32'(gap(C_ACT, C_SRX) >= SR_OT), 1);
		send(C_RD, 2'h0, 1'b0, 3'h0);
		chk(32'(gap(C_RD, C_SRX) >= SR_RD), 1);
		send(C_PDE, 2'h0, 1'b0, 3'h0);
		chk(MEM.cke, 0);
		send(C_PDX, 2'h0, 1'b0, 3'h0);
		send(C_PRE, 2'h0, 1'b0, 3'h0);
		chk(32'(gap(C_PRE, C_SRX) >= `PD_EXIT_CK), 1);
	endtask
	// clock enable low: nothing is taken and the pins hold
	task automatic t_freeze();
		pins_t m;
		m = MEM;
		CE = 1'b0;
		REQ = req_t'{valid: 1'b1, cmd: C_ACT, bank: 2'h1, addr: 12'h000, autopre: 1'b0, wl: 3'h0};
		repeat (4) tick();
		chk(32'(MEM), 32'(m));
		chk(REQ_READY, 1);
		REQ.valid = 1'b0;
		CE = 1'b1;
		repeat (2) tick();
		chk(REQ_READY, 1);
		chk(dev_cmd, C_NOP);
	endtask
	// reset, then each scenario in turn
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		cyc = 0;
		err_seen = 1'b0;
		wr_ap = 1'b0;
		CE = 1'b1;
		REQ = '0;
		RST_N = 1'b0;
		repeat (16) @(posedge CLOCK);
		#1;
		RST_N = 1'b1;
		t_reset();
		t_refresh();
		t_rows();
		for (int w = 1; w <= 7; w++) t_write(3'(w));
		send(C_MRS, 2'h0, 1'b0, 3'h0);
		chk(err_seen, 1);
		t_autopre();
		t_selfref();
		t_freeze();
		chk(dev_viol, 0);
		test_done();
	end
endmodule
`default_nettype wire
